// *** hdl/recfg_pkg.sv ***
package recfg_pkg;
   // apb map, byte addresses of 32-bit words
   localparam logic [7:0] OFS_CTRL  = 8'h00;
   localparam logic [7:0] OFS_STAT  = 8'h04;
   localparam logic [7:0] OFS_WBS   = 8'h08;
   localparam logic [7:0] OFS_HIST  = 8'h0c;
   localparam logic [7:0] OFS_PORT  = 8'h10;
   // control fields
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_ENC      = 3;
   localparam int CTRL_FB_DIS   = 4;
   localparam int CTRL_WDOG     = 5;
   localparam logic [5:0] CTRL_RST = 6'h00;
   // configuration modes
   localparam logic [2:0] MODE_MSERIAL = 3'h0;
   localparam logic [2:0] MODE_SPI     = 3'h1;
   localparam logic [2:0] MODE_PARALLEL_FLASH_INCREMENTING  = 3'h2;
   localparam logic [2:0] MODE_BPI_DN  = 3'h3;
   localparam logic [2:0] MODE_MPAR    = 3'h4;
   localparam logic [2:0] MODE_JTAG    = 3'h5;
   localparam logic [2:0] MODE_SPAR    = 3'h6;
   localparam logic [2:0] MODE_SSERIAL = 3'h7;
   // warm start register: select pins above the flash address
   localparam int WBS_RS_LSB   = 26;
   localparam int FLASH_AW     = 26;
   localparam int SPI_AW       = 24;
   localparam logic [27:0] WBS_RST = 28'h0000000;
   localparam logic [25:0] ADDR_UP_DEF = 26'h0000000;
   localparam logic [25:0] ADDR_DN_DEF = 26'h3ffffff;
   localparam logic [25:0] ADDR_DN_FB  = 26'h00fffff;
   localparam logic [1:0]  RS_FALLBACK = 2'h0;
   // command stream words
   localparam logic [31:0] W_SYNC    = 32'haa995566;
   localparam logic [31:0] H_WBS_WR  = 32'h30020001;
   localparam logic [31:0] H_CMD_WR  = 32'h30008001;
   localparam logic [31:0] C_INTERNAL_PROGRAM_CMD   = 32'h0000000f;
   localparam logic [31:0] C_DESYNC  = 32'h0000000d;
   // history entry: wrap crc id wto internal_program_cmd fallback valid
   localparam int HE_W     = 7;
   localparam int HE_VALID = 0;
   localparam int HE_FB    = 1;
   localparam int HE_INTERNAL_PROGRAM_CMD = 2;
   localparam int HE_WTO   = 3;
   localparam int HE_ID    = 4;
   localparam int HE_CRC   = 5;
   localparam int HE_WRAP  = 6;
   // memory clear time
   localparam int CLK_NS    = 50;
   localparam int CLEAR_NS  = 1000;
   localparam int CLEAR_CYC = (CLEAR_NS + CLK_NS - 1) / CLK_NS;
   typedef enum logic [2:0] {ST_PULSE, ST_CLEAR, ST_LOAD, ST_USER, ST_HALT} state_e;
   typedef enum logic [1:0] {K_FIRST, K_WARM, K_FB} kind_e;
   typedef enum logic [1:0] {DS_HUNT, DS_HDR, DS_WBS, DS_CMD} dec_e;
endpackage

// *** hdl/cfg_word_if.sv ***
`timescale 1ns/1ps
interface cfg_word_if;
   logic        word_valid;
   logic [31:0] word;
   logic        flush;
   logic        wbs_wr;
   logic [27:0] wbs_data;
   logic        internal_program_cmd;
   logic        synced;
   modport dec (input word_valid, word, flush, output wbs_wr, wbs_data, internal_program_cmd, synced);
   modport ctl (output word_valid, word, flush, input wbs_wr, wbs_data, internal_program_cmd, synced);
endinterface

// *** hdl/cfg_word_dec.sv ***
`timescale 1ns/1ps
module cfg_word_dec
   import recfg_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic srst,
   // command stream
   cfg_word_if.dec  cw
);
   dec_e st_r;

   always_ff @(posedge clk_sys) begin
      if (srst || cw.flush) begin
         st_r <= DS_HUNT;
      end else if (cw.word_valid) begin
         case (st_r)
            DS_HUNT: if (cw.word == W_SYNC) st_r <= DS_HDR;
            DS_HDR: begin
               if (cw.word == H_WBS_WR) st_r <= DS_WBS;
               else if (cw.word == H_CMD_WR) st_r <= DS_CMD;
            end
            DS_WBS:  st_r <= DS_HDR;
            DS_CMD: begin
               // desync or warm boot both drop the stream lock
               if (cw.word == C_DESYNC || cw.word == C_INTERNAL_PROGRAM_CMD) st_r <= DS_HUNT;
               else st_r <= DS_HDR;
            end
            default: st_r <= DS_HUNT;
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst || cw.flush) begin
         cw.wbs_wr   <= 1'b0;
         cw.wbs_data <= WBS_RST;
         cw.internal_program_cmd    <= 1'b0;
      end else begin
         cw.wbs_wr <= cw.word_valid && st_r == DS_WBS;
         if (cw.word_valid && st_r == DS_WBS) cw.wbs_data <= cw.word[27:0];
         // a null command patched to low nibble ones is the same word
         cw.internal_program_cmd <= cw.word_valid && st_r == DS_CMD && cw.word == C_INTERNAL_PROGRAM_CMD;
      end
   end

   assign cw.synced = st_r != DS_HUNT;
endmodule

// *** hdl/recfg_ctrl.sv ***
`timescale 1ns/1ps
// How it works
// - reconfig pulse resets config logic; warm start and history registers survive
// - pulse drops init and done, then configuration restarts with memory clear
// - select pins float pulled up first time, pulled down after configuration
// - configuration error pulses reset and drives select pins to 00
// - id, crc, watchdog, wrap errors or user watchdog timeout start fallback
// - failing fallback image halts with init and done held low
// - no fallback with encryption, slave parallel mode, or fallback disabled
// - warm boot command inside a fallback image is ignored
// - watchdog off after fallback until a warm boot load succeeds
// - fallback address zero, or fixed low address in decrementing parallel mode
// - flash reading continues until done goes high
// - warm boot resets like program pin but keeps reconfig state, uses warm start
// - default start address zero, or all ones in decrementing parallel mode
// - header 30020001 then one word loads the warm start register
// - header 30008001 then 0000000f starts warm boot
// - warm boot: init, done low, clear, init high, load from warm start
// - serial flash gets 24-bit address; parallel gets pins and 26 lines
// - select pins follow warm start in all modes; address only in flash modes
// - during warm boot the select pins are actively driven
// - parallel flash pins go to user logic after configuration
// - null command with low four bits set acts as warm boot
// - program pin, jtag program or power-on start initial configuration
// - boot history is a two-entry queue with valid bits
module recfg_ctrl
   import recfg_pkg::*;
#(
   parameter int CLEAR_CYCLES = CLEAR_CYC
)
(
   // clock and reset
   input  wire logic                clk_sys,
   input  wire logic                srst,
   // apb slave
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [7:0]          paddr,
   input  wire logic [31:0]         pwdata,
   output logic      [31:0]         prdata,
   output logic                     pready,
   output logic                     pslverr,
   // configuration start events
   input  wire logic                program_n,
   input  wire logic                jtag_program_instruction,
   // configuration engine
   input  wire logic                img_word_valid,
   input  wire logic [31:0]         img_word,
   input  wire logic                err_id,
   input  wire logic                err_crc,
   input  wire logic                err_wto,
   input  wire logic                err_wrap,
   input  wire logic                usr_wdog_timeout,
   input  wire logic                cfg_complete,
   // sequencing
   output logic                     cfg_reset_pulse,
   output logic                     clear_mem,
   output logic                     init_b,
   output logic                     done,
   output logic                     watchdog_enable,
   output logic                     user_io_release,
   // revision select pins
   output logic      [1:0]          revision_select_pins_out,
   output logic                     revision_select_pins_oe,
   output logic                     revision_select_pins_pu,
   output logic                     revision_select_pins_pd,
   // flash start address
   output logic      [FLASH_AW-1:0] flash_addr,
   output logic                     flash_addr_oe,
   output logic                     flash_read_en,
   output logic      [SPI_AW-1:0]   spi_start_addr,
   output logic                     spi_addr_send
);
   // the clear counter is 16 bits wide, so longer clears cannot be timed
   if (CLEAR_CYCLES < 1 || CLEAR_CYCLES > 65535) begin : g_bad_clear
      $error("CLEAR_CYCLES out of range");
   end

   state_e                state_r;
   kind_e                 kind_r;
   logic [15:0]           clr_cnt_r;
   logic [5:0]            ctrl_r;
   logic [27:0]           warm_start_address_reg;
   logic [2*HE_W-1:0]     boot_history_status_reg;
   logic                  first_done_r;
   logic                  wdog_perm_r;
   logic                  internal_program_cmd_seen_r;
   logic                  port_valid_r;
   logic [31:0]           port_word_r;
   logic [31:0]           prdata_r;
   logic                  full_start;
   logic                  wr_acc;
   logic                  setup;
   logic                  mapped;
   logic                  any_err;
   logic                  fb_allowed;
   logic                  trig_fb;
   logic                  trig_warm;
   logic                  to_halt;
   logic                  load_end;
   logic                  push;
   logic [HE_W-1:0]       entry;
   logic [2:0]            mode;
   logic                  par_mode;
   logic [FLASH_AW-1:0]   start_addr;

   cfg_word_if cw ();

   cfg_word_dec u_dec (
      .clk_sys (clk_sys),
      .srst    (srst),
      .cw      (cw)
   );

   assign mode     = ctrl_r[CTRL_MODE_LSB +: 3];
   assign par_mode = mode == MODE_PARALLEL_FLASH_INCREMENTING || mode == MODE_BPI_DN;

   // program pin or jtag program restart everything, reconfig state too
   assign full_start = !program_n || jtag_program_instruction;
   assign any_err    = err_id || err_crc || err_wto || err_wrap;
   assign fb_allowed = !ctrl_r[CTRL_ENC] && mode != MODE_SPAR && !ctrl_r[CTRL_FB_DIS];

   always_comb begin
      trig_fb   = 1'b0;
      trig_warm = 1'b0;
      to_halt   = 1'b0;
      load_end  = 1'b0;
      if (state_r == ST_LOAD) begin
         if (any_err) begin
            load_end = 1'b1;
            // a second failure has nowhere safer to go
            if (fb_allowed && kind_r != K_FB) trig_fb = 1'b1;
            else to_halt = 1'b1;
         end else if (cw.internal_program_cmd && kind_r != K_FB) begin
            load_end  = 1'b1;
            trig_warm = 1'b1;
         end else if (cfg_complete) begin
            load_end = 1'b1;
         end
      end else if (state_r == ST_USER) begin
         if (usr_wdog_timeout && watchdog_enable && ctrl_r[CTRL_WDOG] && fb_allowed) trig_fb = 1'b1;
         else if (cw.internal_program_cmd) trig_warm = 1'b1;
      end
   end

   // the entry closes the current load before the reset pulse
   assign push = !full_start && (load_end || trig_fb);

   always_comb begin
      entry           = '0;
      entry[HE_VALID] = 1'b1;
      entry[HE_FB]    = kind_r == K_FB;
      // an ignored embedded warm boot is still recorded
      entry[HE_INTERNAL_PROGRAM_CMD] = kind_r == K_WARM || internal_program_cmd_seen_r || cw.internal_program_cmd;
      entry[HE_WTO]   = (state_r == ST_LOAD && err_wto) || state_r == ST_USER;
      entry[HE_ID]    = state_r == ST_LOAD && err_id;
      entry[HE_CRC]   = state_r == ST_LOAD && err_crc;
      entry[HE_WRAP]  = state_r == ST_LOAD && err_wrap;
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         state_r <= ST_CLEAR;
         kind_r  <= K_FIRST;
      end else if (full_start) begin
         state_r <= ST_CLEAR;
         kind_r  <= K_FIRST;
      end else begin
         case (state_r)
            ST_PULSE: state_r <= ST_CLEAR;
            ST_CLEAR: if (clr_cnt_r == 16'(CLEAR_CYCLES - 1)) state_r <= ST_LOAD;
            ST_LOAD, ST_USER: begin
               if (trig_fb) begin
                  state_r <= ST_PULSE;
                  kind_r  <= K_FB;
               end else if (trig_warm) begin
                  state_r <= ST_PULSE;
                  kind_r  <= K_WARM;
               end else if (to_halt) begin
                  state_r <= ST_HALT;
               end else if (state_r == ST_LOAD && cfg_complete) begin
                  state_r <= ST_USER;
               end
            end
            ST_HALT: state_r <= ST_HALT;
            default: state_r <= ST_CLEAR;
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      // a long program pulse must not run the count past its end point
      if (srst || full_start || state_r != ST_CLEAR) clr_cnt_r <= '0;
      else clr_cnt_r <= clr_cnt_r + 16'h0001;
   end

   always_ff @(posedge clk_sys) begin
      if (srst || full_start || state_r == ST_PULSE) internal_program_cmd_seen_r <= 1'b0;
      else if (state_r == ST_LOAD && cw.internal_program_cmd) internal_program_cmd_seen_r <= 1'b1;
   end

   always_ff @(posedge clk_sys) begin
      if (srst || full_start) first_done_r <= 1'b0;
      else if (state_r == ST_LOAD && cfg_complete && !any_err) first_done_r <= 1'b1;
   end

   always_ff @(posedge clk_sys) begin
      if (srst || full_start) begin
         wdog_perm_r <= 1'b1;
      end else if (trig_fb) begin
         wdog_perm_r <= 1'b0;
      end else if (state_r == ST_LOAD && cfg_complete && !any_err && kind_r == K_WARM) begin
         wdog_perm_r <= 1'b1;
      end
   end

   // reconfig pulse spares this register; only program or power-on clears it
   always_ff @(posedge clk_sys) begin
      if (srst || full_start) boot_history_status_reg <= '0;
      else if (push) boot_history_status_reg <= {boot_history_status_reg[HE_W-1:0], entry};
   end

   always_ff @(posedge clk_sys) begin
      if (srst || full_start) begin
         warm_start_address_reg <= WBS_RST;
      end else if (cw.wbs_wr) begin
         warm_start_address_reg <= cw.wbs_data;
      end else if (wr_acc && paddr == OFS_WBS) begin
         warm_start_address_reg <= pwdata[27:0];
      end
   end

   // start address chosen as the memory clear ends
   always_comb begin
      if (kind_r == K_WARM) begin
         start_addr = warm_start_address_reg[FLASH_AW-1:0];
      end else if (kind_r == K_FB) begin
         start_addr = (mode == MODE_BPI_DN) ? ADDR_DN_FB : ADDR_UP_DEF;
      end else begin
         start_addr = (mode == MODE_BPI_DN) ? ADDR_DN_DEF : ADDR_UP_DEF;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         flash_addr     <= ADDR_UP_DEF;
         spi_start_addr <= '0;
         spi_addr_send  <= 1'b0;
      end else begin
         spi_addr_send <= 1'b0;
         if (state_r == ST_CLEAR && clr_cnt_r == 16'(CLEAR_CYCLES - 1) && !full_start) begin
            if (par_mode) flash_addr <= start_addr;
            if (mode == MODE_SPI) begin
               spi_start_addr <= start_addr[SPI_AW-1:0];
               spi_addr_send  <= 1'b1;
            end
         end
      end
   end

   always_comb begin
      revision_select_pins_oe  = kind_r != K_FIRST && state_r inside {ST_PULSE, ST_CLEAR, ST_LOAD};
      revision_select_pins_out = (kind_r == K_FB) ? RS_FALLBACK
                                 : warm_start_address_reg[WBS_RS_LSB +: 2];
      revision_select_pins_pu  = !revision_select_pins_oe && !first_done_r;
      revision_select_pins_pd  = !revision_select_pins_oe && first_done_r;
   end

   assign cfg_reset_pulse = state_r == ST_PULSE;
   assign clear_mem       = state_r == ST_CLEAR;
   assign init_b          = state_r == ST_LOAD || state_r == ST_USER;
   assign done            = state_r == ST_USER;
   assign flash_read_en   = state_r == ST_LOAD;
   assign flash_addr_oe   = state_r == ST_LOAD && par_mode;
   assign user_io_release = state_r == ST_USER;
   assign watchdog_enable = wdog_perm_r && kind_r != K_FB;

   // image words while loading, internal port words once running
   assign cw.word_valid = (state_r == ST_LOAD) ? img_word_valid
                        : (state_r == ST_USER && port_valid_r);
   assign cw.word       = (state_r == ST_LOAD) ? img_word : port_word_r;
   assign cw.flush      = state_r == ST_PULSE || state_r == ST_CLEAR || full_start;

   // apb: zero wait states, read data captured in the setup cycle
   assign setup   = psel && !penable;
   assign wr_acc  = psel && penable && pwrite;
   assign mapped  = paddr inside {OFS_CTRL, OFS_STAT, OFS_WBS, OFS_HIST, OFS_PORT};
   assign pready  = 1'b1;
   assign pslverr = psel && penable && !mapped;
   assign prdata  = prdata_r;

   always_ff @(posedge clk_sys) begin
      if (srst) ctrl_r <= CTRL_RST;
      else if (wr_acc && paddr == OFS_CTRL) ctrl_r <= pwdata[5:0];
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         port_valid_r <= 1'b0;
         port_word_r  <= '0;
      end else begin
         port_valid_r <= wr_acc && paddr == OFS_PORT;
         if (wr_acc && paddr == OFS_PORT) port_word_r <= pwdata;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         prdata_r <= '0;
      end else if (setup && !pwrite) begin
         case (paddr)
            OFS_CTRL: prdata_r <= {26'h0, ctrl_r};
            OFS_STAT: prdata_r <= {22'h0, cw.synced, kind_r, first_done_r, watchdog_enable,
                                   init_b, done, state_r};
            OFS_WBS:  prdata_r <= {4'h0, warm_start_address_reg};
            OFS_HIST: prdata_r <= {18'h0, boot_history_status_reg};
            default:  prdata_r <= '0;
         endcase
      end
   end
endmodule

// *** tb/recfg_ctrl_properties.sv ***
`timescale 1ns/1ps
module recfg_ctrl_properties (
   // clock and reset
   input wire logic clk_sys,
   input wire logic srst,
   // sequencing and pins
   input wire logic cfg_reset_pulse,
   input wire logic clear_mem,
   input wire logic init_b,
   input wire logic done,
   input wire logic user_io_release,
   input wire logic flash_read_en,
   input wire logic flash_addr_oe,
   input wire logic revision_select_pins_oe,
   input wire logic revision_select_pins_pd,
   // start events and load errors
   input wire logic program_n,
   input wire logic jtag_program_instruction,
   input wire logic err_id,
   input wire logic err_crc,
   input wire logic err_wto,
   input wire logic err_wrap
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (srst);
   property p_pulse_drops; cfg_reset_pulse |=> !init_b && !done; endproperty
   a_pulse_drops: assert property (p_pulse_drops) else $error("init or done high after pulse");
   property p_pulse_clear; cfg_reset_pulse |=> clear_mem; endproperty
   a_pulse_clear: assert property (p_pulse_clear) else $error("no clear after pulse");
   property p_clear_low; clear_mem |-> !init_b && !done; endproperty
   a_clear_low: assert property (p_clear_low) else $error("init or done high in clear");
   property p_clear_end; $fell(clear_mem) |-> init_b && flash_read_en; endproperty
   a_clear_end: assert property (p_clear_end) else $error("no load after clear");
   property p_read_stop;
      $fell(flash_read_en) |-> done || cfg_reset_pulse || $past(srst) || !$past(program_n)
         || $past(jtag_program_instruction) || $past(err_id) || $past(err_crc) || $past(err_wto) || $past(err_wrap);
   endproperty
   a_read_stop: assert property (p_read_stop) else $error("flash read stopped early");
   property p_user_pins; done |-> user_io_release && !flash_addr_oe; endproperty
   a_user_pins: assert property (p_user_pins) else $error("flash pins kept after done");
   property p_rs_pd; done |-> revision_select_pins_pd && !revision_select_pins_oe; endproperty
   a_rs_pd: assert property (p_rs_pd) else $error("select pins not pulled down");
   property p_rs_drv;
      cfg_reset_pulse |-> revision_select_pins_oe
         ##1 (revision_select_pins_oe || !$past(program_n) || $past(jtag_program_instruction));
   endproperty
   a_rs_drv: assert property (p_rs_drv) else $error("select pins not driven");
endmodule
bind recfg_ctrl recfg_ctrl_properties chk_u (.clk_sys, .srst, .cfg_reset_pulse, .clear_mem, .init_b, .done,
   .user_io_release, .flash_read_en, .flash_addr_oe, .revision_select_pins_oe, .revision_select_pins_pd,
   .program_n, .jtag_program_instruction, .err_id, .err_crc, .err_wto, .err_wrap);

// *** tb/cfg_flash_model.sv ***
`timescale 1ns/1ps
module cfg_flash_model
   import recfg_pkg::*;
(
   // load handshake
   input  wire logic        clk_sys,
   input  wire logic        flash_read_en,
   input  wire logic [2:0]  fault,
   // image stream and outcome
   output logic             img_word_valid,
   output logic [31:0]      img_word,
   output logic             cfg_complete,
   output logic [3:0]       err
);
   logic [3:0] cnt_r = 4'h0;
   logic [7:0] tick_r = 8'h00;
   always_ff @(posedge clk_sys) begin
      tick_r <= tick_r + 8'h01;
      if (!flash_read_en)
         cnt_r <= 4'h0;
      else if (cnt_r != 4'hf)
         cnt_r <= cnt_r + 4'h1;
   end
   // idle bus moves every cycle so a stale word never passes for data
   // fault 5: the image carries a warm boot command and otherwise loads cleanly
   assign img_word_valid = flash_read_en && (cnt_r == 4'h2 || cnt_r == 4'h3 || (fault == 3'h5 && cnt_r == 4'h4));
   assign img_word       = !img_word_valid ? {4{tick_r}} : (cnt_r == 4'h2) ? W_SYNC : (cnt_r == 4'h4) ? C_INTERNAL_PROGRAM_CMD
                         : (fault == 3'h5) ? H_CMD_WR : 32'h20000000;
   assign cfg_complete   = flash_read_en && cnt_r == 4'h5 && (fault == 3'h0 || fault == 3'h5);
   // fault 1..4 picks id, crc, watchdog, wrap
   always_comb for (int i = 0; i < 4; i++) err[i] = flash_read_en && cnt_r == 4'h5 && fault == 3'(i + 1);
endmodule

// *** tb/recfg_ctrl_tb.sv ***
`timescale 1ns/1ps
module recfg_ctrl_tb import recfg_pkg::*; ;
   logic        clk_sys = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, program_n = 1, e;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, q, img_word;
   logic        pready, pslverr, img_word_valid, cfg_complete, cfg_reset_pulse, clear_mem, init_b, done;
   logic        watchdog_enable, user_io_release, flash_addr_oe, flash_read_en, spi_addr_send;
   logic        revision_select_pins_oe, revision_select_pins_pu, revision_select_pins_pd;
   logic [1:0]  revision_select_pins_out;
   logic [25:0] flash_addr;
   logic [23:0] spi_start_addr;
   logic [3:0]  err;
   logic [2:0]  fault = 3'h0;
   int          fail_count = 0, num_checks = 0, cyc = 0;
   recfg_ctrl #(.CLEAR_CYCLES(2)) dut_u (.clk_sys, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .program_n, .jtag_program_instruction(1'b0), .img_word_valid, .img_word,
      .err_id(err[0]), .err_crc(err[1]), .err_wto(err[2]), .err_wrap(err[3]), .usr_wdog_timeout(1'b0),
      .cfg_complete, .cfg_reset_pulse, .clear_mem, .init_b, .done, .watchdog_enable, .user_io_release,
      .revision_select_pins_out, .revision_select_pins_oe, .revision_select_pins_pu, .revision_select_pins_pd,
      .flash_addr, .flash_addr_oe, .flash_read_en, .spi_start_addr, .spi_addr_send);
   cfg_flash_model flash_u (.clk_sys, .flash_read_en, .fault, .img_word_valid, .img_word, .cfg_complete, .err);
   initial begin
      forever #25 clk_sys = ~clk_sys;
   end
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         fail_count++;
         give_verdict();
      end
   end
   task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
      num_checks++;
      if (g !== x) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", n, x, g);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1;
      do @(posedge clk_sys); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   // polls state until it matches; the cycle ceiling ends a hang
   task automatic till(input logic [2:0] s);
      do apb(0, OFS_STAT, 0); while (q[2:0] !== s);
   endtask
   task automatic warm(input logic [27:0] w);
      apb(1, OFS_PORT, W_SYNC);
      apb(1, OFS_PORT, H_WBS_WR);
      apb(1, OFS_PORT, {4'h0, w});
      apb(1, OFS_PORT, H_CMD_WR);
      apb(1, OFS_PORT, C_INTERNAL_PROGRAM_CMD);
      while (cfg_reset_pulse !== 1'b1) @(posedge clk_sys);
   endtask
   task automatic wait_rd(input logic lvl);
      while (flash_read_en !== lvl) @(posedge clk_sys);
   endtask
   task automatic t_first();
      chk("rs pullup", 1, revision_select_pins_pu);
      chk("rs oe", 0, revision_select_pins_oe);
      till(3'h3);
      apb(0, OFS_HIST, 0);
      chk("history", 32'h1, q);
      apb(0, 8'h20, 0);
      chk("unmapped err", 1, e);
      chk("unmapped data", 0, q);
      $display("first config done");
   endtask
   task automatic t_warm();
      apb(1, OFS_CTRL, {29'h0, MODE_PARALLEL_FLASH_INCREMENTING});
      warm(28'hc123456);
      chk("rs oe", 1, revision_select_pins_oe);
      chk("rs out", 2'h3, revision_select_pins_out);
      wait_rd(1);
      chk("flash addr", 26'h0123456, flash_addr);
      chk("addr oe", 1, flash_addr_oe);
      till(3'h3);
      apb(0, OFS_WBS, 0);
      chk("warm start", 28'hc123456, q);
      apb(0, OFS_HIST, 0);
      chk("history", 32'h85, q);
      $display("warm boot done");
   endtask
   task automatic t_spi();
      apb(1, OFS_CTRL, {29'h0, MODE_SPI});
      warm(28'h5abcdef);
      chk("rs out", 2'h1, revision_select_pins_out);
      wait_rd(1);
      chk("spi send", 1, spi_addr_send);
      chk("spi addr", 24'habcdef, spi_start_addr);
      chk("addr oe", 0, flash_addr_oe);
      chk("flash addr", 26'h0123456, flash_addr);
      till(3'h3);
      $display("serial flash warm boot done");
   endtask
   task automatic t_fallback();
      apb(1, OFS_CTRL, {29'h0, MODE_BPI_DN});
      fault <= 3'h2;
      warm(28'h8000040);
      chk("rs warm", 2'h2, revision_select_pins_out);
      wait_rd(1);
      while (cfg_reset_pulse !== 1'b1) @(posedge clk_sys);
      // the safe image carries its own warm boot command, which must be ignored
      fault <= 3'h5;
      chk("rs fallback", RS_FALLBACK, revision_select_pins_out);
      wait_rd(1);
      chk("fallback addr", ADDR_DN_FB, flash_addr);
      till(3'h3);
      chk("watchdog", 0, watchdog_enable);
      apb(0, OFS_HIST, 0);
      chk("history", 32'h1287, q);
      fault <= 3'h0;
      warm(28'h0);
      till(3'h3);
      chk("watchdog back", 1, watchdog_enable);
      $display("fallback done");
   endtask
   task automatic t_halt();
      fault <= 3'h1;
      warm(28'h0);
      wait_rd(1);
      wait_rd(0);
      fault <= 3'h3;
      till(3'h4);
      chk("init halt", 0, init_b);
      chk("done halt", 0, done);
      apb(0, OFS_HIST, 0);
      chk("history", 32'ha8b, q);
      $display("halt done");
   endtask
   task automatic t_nofb(input logic [31:0] c);
      @(posedge clk_sys);
      program_n <= 0;
      fault <= 3'h0;
      repeat (4) @(posedge clk_sys);
      program_n <= 1;
      till(3'h3);
      apb(0, OFS_HIST, 0);
      chk("history", 32'h1, q);
      apb(1, OFS_CTRL, c);
      fault <= 3'h4;
      warm(28'h0);
      wait_rd(1);
      wait_rd(0);
      fault <= 3'h0;
      till(3'h4);
      chk("init nofb", 0, init_b);
      $display("fallback disabled done");
   endtask
   initial begin
      repeat (5) @(posedge clk_sys);
      srst <= 0;
      @(posedge clk_sys);
      t_first();
      t_warm();
      t_spi();
      t_fallback();
      t_halt();
      t_nofb(32'h12);
      t_nofb(32'h0a);
      t_nofb(32'h06);
      give_verdict();
   end
endmodule
